// *** rtl/mrwh_pkg.sv ***
// constants and helper functions shared by the register write handler
package mrwh_pkg;

    // ==========================================================
    // function codes, exception flag and error codes
    localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] ERR_FUNC = 8'h01;
    localparam logic [7:0] ERR_ADDR = 8'h02;
    localparam logic [7:0] ERR_DATA = 8'h03;

    // ==========================================================
    // holding register offsets and reset values
    localparam logic [15:0] REG_CH1_SET_TEMP = 16'h0040;
    localparam logic [15:0] REG_CH2_SET_TEMP = 16'h0041;
    localparam logic [15:0] REG_RUN_MODE = 16'h0042;
    localparam logic [15:0] RST_CH1_SET_TEMP = 16'h0000;
    localparam logic [15:0] RST_CH2_SET_TEMP = 16'h0000;
    localparam logic [15:0] RST_RUN_MODE = 16'h0000;

    // ==========================================================
    // framing characters and checksum constants
    localparam logic [7:0] ASCII_HEADER = 8'h3A;
    localparam logic [7:0] ASCII_CR = 8'h0D;
    localparam logic [7:0] ASCII_LF = 8'h0A;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [7:0] LRC_INIT = 8'h00;

    // ==========================================================
    // sizes and timing
    localparam int FRAME_MAX = 32;
    localparam int LEN_W = 6;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_RATE = 9600;
    localparam int CHAR_BITS = 11;
    localparam int GAP_CHARS_X10 = 35;
    localparam int CHAR_CYC = (CLK_HZ * CHAR_BITS + BAUD_RATE - 1) / BAUD_RATE;
    localparam int GAP_CYC = (CHAR_CYC * GAP_CHARS_X10 + 9) / 10;
    localparam int GAP_W = 24;

    // ==========================================================
    // one byte step of the reflected crc
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++)
        begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    // true for an ascii hex digit, either case
    function automatic logic is_hex(input logic [7:0] c);
        return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
               (c >= 8'h61 && c <= 8'h66);
    endfunction : is_hex

    // value of an ascii hex digit
    function automatic logic [3:0] hex_val(input logic [7:0] c);
        return c[6] ? 4'(c[3:0] + 4'h9) : c[3:0];
    endfunction : hex_val

    // ascii hex digit for a nibble, upper case
    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n < 4'hA) ? 8'(8'h30 + {4'h0, n}) : 8'(8'h37 + {4'h0, n});
    endfunction : hex_char

    // writable holding register window
    function automatic logic in_range(input logic [15:0] a);
        return a >= REG_CH1_SET_TEMP && a <= REG_RUN_MODE;
    endfunction : in_range

endpackage : mrwh_pkg

// *** rtl/mrwh_stream_if.sv ***
// valid/ready byte stream between the handler and its fifo
interface mrwh_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source(output valid, output data, input ready);
    modport sink(input valid, input data, output ready);
endinterface : mrwh_stream_if

// *** rtl/mrwh_fifo.sv ***
// small synchronous fifo for the reply byte stream
module mrwh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock_in, // system clock
    input wire logic rst_in, // async reset, active high
    mrwh_stream_if.sink push_if, // filling side
    output logic [WIDTH-1:0] data_out, // head word
    output logic valid_out, // head word valid
    input wire logic ready_in // drain side accepts head
);
    import mrwh_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;

    // ==========================================================
    // handshake terms
    assign push_if.ready = (count != (AW+1)'(DEPTH));
    assign valid_out = (count != '0);
    assign do_push = push_if.valid && push_if.ready;
    assign do_pop = valid_out && ready_in;
    assign data_out = mem[rd_ptr];

    // storage
    always_ff @(posedge clock_in)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= push_if.data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (do_pop)
            begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            if (do_push && !do_pop)
            begin
                count <= (AW+1)'(count + 1'b1);
            end
            else if (do_pop && !do_push)
            begin
                count <= (AW+1)'(count - 1'b1);
            end
        end
    end

endmodule : mrwh_fifo

// *** rtl/mrwh_top.sv ***
// register write command handler for a serial slave, ascii and rtu framing
//
// How it works
// - a valid single write stores its value in the addressed register.
// - a successful single write is answered with a copy of the request.
// - a valid multiple write fills consecutive registers from the start.
// - a multiple write gets slave, function, start, count, new checksum.
// - ascii frames: colon, bytes as hex pairs, lrc, then cr lf.
// - 0x40 and 0x41 hold set temperatures, 0x42 takes run commands.
// - the rtu crc goes out low byte first, then high byte.
// - rtu frames sit between idle gaps of at least 3.5 char times.
// - bad function, address, data: function plus 0x80, code 01, 02, 03.
module mrwh_top #(
    parameter int GAP_CYCLES = mrwh_pkg::GAP_CYC
) (
    input wire logic clock_in, // system clock
    input wire logic rst_in, // async reset, active high
    input wire logic ascii_mode_in, // 1 ascii framing, 0 rtu
    input wire logic [7:0] dev_addr_in, // own slave address
    input wire logic [7:0] rx_data_in, // received byte or char
    input wire logic rx_valid_in, // rx_data_in valid pulse
    output logic [7:0] tx_data_out, // reply byte or char
    output logic tx_valid_out, // tx_data_out valid
    input wire logic tx_ready_in, // transmitter takes byte
    output logic [15:0] ch1_set_temperature_out, // channel 1 set value
    output logic [15:0] ch2_set_temperature_out, // channel 2 set value
    output logic [15:0] run_mode_request_out, // run mode command
    output logic busy_out // checking, writing or replying
);
    import mrwh_pkg::*;

    typedef enum {ST_RX, ST_CHECK, ST_WRITE, ST_TX} mrwh_state_t;
    typedef enum {TP_HDR, TP_DATA, TP_CK0, TP_CK1, TP_CR, TP_LF} mrwh_phase_t;

    localparam logic [GAP_W-1:0] GAP_LIM = GAP_W'(GAP_CYCLES);

    mrwh_state_t state;
    mrwh_phase_t phase;
    logic [7:0] frame_buf [FRAME_MAX];
    logic [LEN_W-1:0] len;
    logic [15:0] rx_crc;
    logic [7:0] rx_lrc;
    logic rx_bad;
    logic in_frame;
    logic nib;
    logic [3:0] hi_nib;
    logic [GAP_W-1:0] gap_cnt;
    logic gap_done;
    logic commit;
    logic [7:0] commit_val;
    logic frame_end;
    logic [7:0] rbuf [6];
    logic [2:0] rlen;
    logic [2:0] ti;
    logic tnib;
    logic [15:0] tx_crc;
    logic [7:0] tx_lrc;
    logic [3:0] wr_idx;
    logic wr_en;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic [LEN_W-1:0] plen;
    logic [15:0] start;
    logic [15:0] cnt;
    logic chk_ok;
    logic [7:0] err_code;
    logic last_word;
    logic [7:0] cur_b;
    logic byte_fin;
    logic push_ok;
    mrwh_stream_if #(.WIDTH(FIFO_WIDTH)) tx_stream();

    // ==========================================================
    // receive side
    // idle line timer, saturates once the gap is long enough
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            gap_cnt <= '0;
        end
        else if (rx_valid_in)
        begin
            gap_cnt <= '0;
        end
        else if (!gap_done)
        begin
            gap_cnt <= GAP_W'(gap_cnt + 1'b1);
        end
    end
    assign gap_done = (gap_cnt == GAP_LIM);

    // decoded byte to store: raw in rtu, hex pair in ascii
    always_comb
    begin
        commit = 1'b0;
        commit_val = rx_data_in;
        if (state == ST_RX && rx_valid_in)
        begin
            if (!ascii_mode_in)
            begin
                commit = 1'b1;
            end
            else if (in_frame && is_hex(rx_data_in) && nib)
            begin
                commit = 1'b1;
                commit_val = {hi_nib, hex_val(rx_data_in)};
            end
        end
    end

    // end of frame: cr in ascii, idle gap in rtu
    assign frame_end = (state == ST_RX) &&
        (ascii_mode_in ? (rx_valid_in && in_frame && rx_data_in == ASCII_CR)
                       : (len != '0 && gap_done && !rx_valid_in));

    // frame buffer
    always_ff @(posedge clock_in)
    begin
        if (commit && len < LEN_W'(FRAME_MAX))
        begin
            frame_buf[len[4:0]] <= commit_val;
        end
    end

    // length, running checksums and framing error flag
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            len <= '0;
            rx_crc <= CRC_INIT;
            rx_lrc <= LRC_INIT;
            rx_bad <= 1'b0;
            in_frame <= 1'b0;
            nib <= 1'b0;
            hi_nib <= 4'h0;
        end
        else if (state != ST_RX)
        begin
            len <= '0;
            in_frame <= 1'b0;
            nib <= 1'b0;
        end
        else if (rx_valid_in && ascii_mode_in && rx_data_in == ASCII_HEADER)
        begin
            len <= '0;
            in_frame <= 1'b1;
            nib <= 1'b0;
            rx_bad <= 1'b0;
        end
        else if (commit)
        begin
            len <= (len < LEN_W'(FRAME_MAX)) ? LEN_W'(len + 1'b1) : len;
            rx_crc <= crc_step((len == '0) ? CRC_INIT : rx_crc, commit_val);
            rx_lrc <= 8'(((len == '0) ? LRC_INIT : rx_lrc) + commit_val);
            nib <= 1'b0;
            if (len == '0)
            begin
                rx_bad <= ascii_mode_in ? 1'b0 : !gap_done;
            end
            else if (len == LEN_W'(FRAME_MAX))
            begin
                rx_bad <= 1'b1;
            end
        end
        else if (rx_valid_in && ascii_mode_in && in_frame)
        begin
            if (is_hex(rx_data_in))
            begin
                hi_nib <= hex_val(rx_data_in);
                nib <= 1'b1;
            end
            else if (rx_data_in == ASCII_CR)
            begin
                rx_bad <= rx_bad || nib;
                in_frame <= 1'b0;
            end
            else if (rx_data_in != ASCII_LF)
            begin
                rx_bad <= 1'b1;
            end
        end
    end

    // ==========================================================
    // request decode
    always_comb
    begin
        plen = LEN_W'(len - (ascii_mode_in ? 1'b1 : 2'd2));
        start = {frame_buf[2], frame_buf[3]};
        cnt = {frame_buf[4], frame_buf[5]};
        chk_ok = !rx_bad && len >= LEN_W'(4) && frame_buf[0] == dev_addr_in &&
            (ascii_mode_in ? rx_lrc == 8'h00 : rx_crc == 16'h0000);
        err_code = 8'h00;
        if (frame_buf[1] == FUNC_WRITE_SINGLE)
        begin
            if (plen != LEN_W'(6))
            begin
                err_code = ERR_DATA;
            end
            else if (!in_range(start))
            begin
                err_code = ERR_ADDR;
            end
        end
        else if (frame_buf[1] == FUNC_WRITE_MULTI)
        begin
            if (plen < LEN_W'(7) || cnt == 16'h0000 || cnt[15:7] != '0 ||
                frame_buf[6] != {cnt[6:0], 1'b0} ||
                {3'b000, plen} != 9'(9'd7 + {1'b0, frame_buf[6]}))
            begin
                err_code = ERR_DATA;
            end
            else if (!in_range(start) ||
                17'({1'b0, start} + {1'b0, cnt} - 17'd1) >
                {1'b0, REG_RUN_MODE})
            begin
                err_code = ERR_ADDR;
            end
        end
        else
        begin
            err_code = ERR_FUNC;
        end
    end

    // register write port
    always_comb
    begin
        wr_en = 1'b0;
        wr_addr = start;
        wr_data = {frame_buf[4], frame_buf[5]};
        last_word = ({12'h000, wr_idx} == 16'(cnt - 16'd1));
        if (state == ST_CHECK && chk_ok && err_code == 8'h00 &&
            frame_buf[1] == FUNC_WRITE_SINGLE)
        begin
            wr_en = 1'b1;
        end
        else if (state == ST_WRITE)
        begin
            wr_en = 1'b1;
            wr_addr = 16'(start + {12'h000, wr_idx});
            wr_data = {frame_buf[5'(5'd7 + {wr_idx, 1'b0})],
                       frame_buf[5'(5'd8 + {wr_idx, 1'b0})]};
        end
    end

    // holding registers
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ch1_set_temperature_out <= RST_CH1_SET_TEMP;
            ch2_set_temperature_out <= RST_CH2_SET_TEMP;
            run_mode_request_out <= RST_RUN_MODE;
        end
        else if (wr_en)
        begin
            case (wr_addr)
                REG_CH1_SET_TEMP: ch1_set_temperature_out <= wr_data;
                REG_CH2_SET_TEMP: ch2_set_temperature_out <= wr_data;
                REG_RUN_MODE: run_mode_request_out <= wr_data;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // control sequence
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= ST_RX;
            wr_idx <= 4'h0;
        end
        else
        begin
            case (state)
                ST_RX:
                begin
                    if (frame_end)
                    begin
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK:
                begin
                    wr_idx <= 4'h0;
                    if (!chk_ok)
                    begin
                        state <= ST_RX;
                    end
                    else if (err_code == 8'h00 &&
                             frame_buf[1] == FUNC_WRITE_MULTI)
                    begin
                        state <= ST_WRITE;
                    end
                    else
                    begin
                        state <= ST_TX;
                    end
                end
                ST_WRITE:
                begin
                    wr_idx <= 4'(wr_idx + 1'b1);
                    if (last_word)
                    begin
                        state <= ST_TX;
                    end
                end
                ST_TX:
                begin
                    if (push_ok && byte_fin && (phase == TP_LF ||
                        (!ascii_mode_in && phase == TP_CK1)))
                    begin
                        state <= ST_RX;
                    end
                end
                default: state <= ST_RX;
            endcase
        end
    end

    // ==========================================================
    // reply build and serialisation
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rlen <= 3'd0;
            for (int i = 0; i < 6; i++)
            begin
                rbuf[i] <= 8'h00;
            end
        end
        else if (state == ST_CHECK)
        begin
            if (err_code != 8'h00)
            begin
                rbuf[0] <= frame_buf[0];
                rbuf[1] <= frame_buf[1] | EXC_FLAG;
                rbuf[2] <= err_code;
                rlen <= 3'd3;
            end
            else
            begin
                for (int i = 0; i < 6; i++)
                begin
                    rbuf[i] <= frame_buf[i];
                end
                rlen <= 3'd6;
            end
        end
    end

    // byte in flight and whether this char completes it
    always_comb
    begin
        case (phase)
            TP_CK0: cur_b = ascii_mode_in ? 8'(8'h00 - tx_lrc) : tx_crc[7:0];
            TP_CK1: cur_b = tx_crc[15:8];
            default: cur_b = rbuf[ti];
        endcase
        byte_fin = !ascii_mode_in || tnib || phase == TP_HDR ||
            phase == TP_CR || phase == TP_LF;
        case (phase)
            TP_HDR: tx_stream.data = ASCII_HEADER;
            TP_CR: tx_stream.data = ASCII_CR;
            TP_LF: tx_stream.data = ASCII_LF;
            default: tx_stream.data = !ascii_mode_in ? cur_b :
                (tnib ? hex_char(cur_b[3:0]) : hex_char(cur_b[7:4]));
        endcase
    end
    assign tx_stream.valid = (state == ST_TX);
    assign push_ok = tx_stream.valid && tx_stream.ready;
    assign busy_out = (state != ST_RX);

    // phase walk of the reply
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            phase <= TP_DATA;
            ti <= 3'd0;
            tnib <= 1'b0;
            tx_crc <= CRC_INIT;
            tx_lrc <= LRC_INIT;
        end
        else if (state != ST_TX)
        begin
            phase <= ascii_mode_in ? TP_HDR : TP_DATA;
            ti <= 3'd0;
            tnib <= 1'b0;
            tx_crc <= CRC_INIT;
            tx_lrc <= LRC_INIT;
        end
        else if (push_ok)
        begin
            tnib <= ascii_mode_in && !byte_fin;
            if (byte_fin)
            begin
                case (phase)
                    TP_HDR: phase <= TP_DATA;
                    TP_DATA:
                    begin
                        tx_crc <= crc_step(tx_crc, cur_b);
                        tx_lrc <= 8'(tx_lrc + cur_b);
                        ti <= 3'(ti + 1'b1);
                        if (ti == 3'(rlen - 1'b1))
                        begin
                            phase <= TP_CK0;
                        end
                    end
                    TP_CK0: phase <= ascii_mode_in ? TP_CR : TP_CK1;
                    TP_CR: phase <= TP_LF;
                    default: phase <= TP_DATA;
                endcase
            end
        end
    end

    // reply fifo toward the transmitter
    mrwh_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .push_if(tx_stream),
        .data_out(tx_data_out),
        .valid_out(tx_valid_out),
        .ready_in(tx_ready_in)
    );

endmodule : mrwh_top

// *** tb/mrwh_chk.sv ***
// port assertions for the register write handler
module mrwh_chk #(
    parameter int GAP_CYCLES = 20
) (
    input wire logic clock_in, // clk
    input wire logic rst_in, // reset
    input wire logic ascii_mode_in, // ascii
    input wire logic rx_valid_in, // rx strobe
    input wire logic [7:0] tx_data_out, // tx char
    input wire logic tx_valid_out, // tx valid
    input wire logic tx_ready_in, // tx ready
    input wire logic [15:0] ch1_set_temperature_out, // reg
    input wire logic [15:0] ch2_set_temperature_out, // reg
    input wire logic [15:0] run_mode_request_out, // reg
    input wire logic busy_out // busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] idle;
    logic first;
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    // ====
    // helpers: cycles since the last rx byte
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            idle <= 8'h00;
        else
            idle <= rx_valid_in ? 8'h00 : idle + {7'h00, idle != 8'hFF};
    end
    // the char after a line feed opens a reply
    always_ff @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            first <= 1'b1;
        else if (tx_valid_out && tx_ready_in)
            first <= tx_data_out == 8'h0A;
    end
    // ====
    // assertions
    property p_regs;
        $changed({ch1_set_temperature_out, ch2_set_temperature_out,
            run_mode_request_out}) |-> busy_out || $past(busy_out);
    endproperty
    a_regs: assert property (p_regs) else $error("idle write");
    property p_rise;
        $rose(tx_valid_out) |-> busy_out || $past(busy_out);
    endproperty
    a_rise: assert property (p_rise) else $error("idle reply");
    property p_gap;
        !ascii_mode_in && rx_valid_in && !busy_out |=> !busy_out [*8];
    endproperty
    a_gap: assert property (p_gap) else $error("gap short");
    property p_glen;
        !ascii_mode_in && $rose(busy_out) |-> idle >= GAP_CYCLES - 1;
    endproperty
    a_glen: assert property (p_glen) else $error("gap len");
    property p_hold;
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("tx lost");
    property p_colon;
        ascii_mode_in && tx_valid_out && first |-> tx_data_out == 8'h3A;
    endproperty
    a_colon: assert property (p_colon) else $error("no colon");
    property p_char;
        ascii_mode_in && tx_valid_out |-> tx_data_out inside
            {[8'h30:8'h39], [8'h41:8'h46], 8'h3A, 8'h0D, 8'h0A};
    endproperty
    a_char: assert property (p_char) else $error("bad char");
    property p_crlf;
        ascii_mode_in && tx_valid_out && tx_ready_in && tx_data_out == 8'h0D
            |=> tx_valid_out && tx_data_out == 8'h0A;
    endproperty
    a_crlf: assert property (p_crlf) else $error("no lf");
endmodule : mrwh_chk

bind mrwh_top mrwh_chk #(.GAP_CYCLES(GAP_CYCLES)) mrwh_chk_i (.*);

// *** tb/mrwh_master.sv ***
// serial master model: sends frames, gathers replies
module mrwh_master #(
    parameter int GAP = 20
) (
    input wire logic clock_in, // clk
    input wire logic ascii_in, // ascii
    input wire logic slow_in, // stall
    output logic [7:0] rx_data_out, // char out
    output logic rx_valid_out, // strobe
    input wire logic [7:0] tx_data_in, // reply
    input wire logic tx_valid_in, // valid
    output logic tx_ready_out // ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got[$];
    logic [2:0] cyc = 3'h0;
    initial rx_valid_out = 1'b0;
    initial rx_data_out = 8'h00;
    // a slow master takes one char in eight
    assign tx_ready_out = !slow_in || cyc == 3'h0;
    // ====
    // reply gathering
    always @(posedge clock_in)
    begin
        cyc <= cyc + 3'h1;
        if (tx_valid_in && tx_ready_out)
            got.push_back(tx_data_in);
    end
    // frame a message; bad spoils the checksum
    function automatic void enc(input logic [7:0] b[$], input logic bad,
        output logic [7:0] f[$]);
        logic [7:0] s;
        logic [15:0] c;
        s = {7'h00, bad};
        c = 16'hFFFF;
        foreach (b[i])
        begin
            s = s - b[i];
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        f = {b, c[7:0] ^ {7'h00, bad}, c[15:8]};
        if (ascii_in)
        begin
            b.push_back(s);
            f = {8'h3A};
            foreach (b[i])
                for (int n = 4; n >= 0; n -= 4)
                    f.push_back(8'(b[i][n+:4]) + (b[i][n+:4] > 4'h9 ?
                        8'h37 : 8'h30));
            f = {f, 8'h0D, 8'h0A};
        end
    endfunction : enc
    // drive a frame, rtu only after an idle gap
    task automatic send(input logic [7:0] f[$]);
        if (!ascii_in)
            repeat (GAP + 5) @(posedge clock_in);
        foreach (f[i])
        begin
            @(posedge clock_in);
            #1 rx_data_out = f[i];
            rx_valid_out = 1'b1;
            @(posedge clock_in);
            #1 rx_valid_out = 1'b0;
            rx_data_out = ~f[i];
        end
    endtask : send
endmodule : mrwh_master

// *** tb/test_mrwh_top.sv ***
// self-checking bench of the register write handler
module test_mrwh_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic ascii = 1'b1;
    logic slow = 1'b1;
    logic [7:0] rxd, txd;
    logic rxv, txv, txr, busy;
    logic [15:0] t1, t2, rm;
    logic [7:0] q[$];
    logic [7:0] g[$];
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    mrwh_top #(.GAP_CYCLES(20)) mrwh_top_i (.clock_in(clock_in),
        .rst_in(rst_in), .ascii_mode_in(ascii), .dev_addr_in(8'h01),
        .rx_data_in(rxd), .rx_valid_in(rxv), .tx_data_out(txd),
        .tx_valid_out(txv), .tx_ready_in(txr),
        .ch1_set_temperature_out(t1), .ch2_set_temperature_out(t2),
        .run_mode_request_out(rm), .busy_out(busy));
    mrwh_master #(.GAP(20)) mrwh_master_i (.clock_in(clock_in),
        .ascii_in(ascii), .slow_in(slow), .rx_data_out(rxd),
        .rx_valid_out(rxv), .tx_data_in(txd), .tx_valid_in(txv),
        .tx_ready_out(txr));
    // 100 MHz clock
    always #5 clock_in = ~clock_in;
    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, seen, want);
        end
    endtask : chk
    // verdict and end of run
    task automatic results;
        if (error_cnt == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results
    // one request, then wait until the reply has drained
    task automatic xfer(input logic [7:0] m[$], input logic bad);
        int idle;
        mrwh_master_i.enc(m, bad, q);
        mrwh_master_i.got = {};
        mrwh_master_i.send(q);
        idle = 0;
        while (idle < 40)
        begin
            @(posedge clock_in);
            idle = (busy || txv) ? 0 : idle + 1;
        end
        #1 g = mrwh_master_i.got;
    endtask : xfer
    // compare the gathered reply with message m framed
    task automatic rep(input logic [7:0] m[$]);
        mrwh_master_i.enc(m, 1'b0, q);
        chk(16'(g.size()), 16'(q.size()));
        foreach (q[i])
            chk({8'h00, g[i]}, {8'h00, q[i]});
    endtask : rep
    // run time ceiling
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            results();
        end
    end
    // ====
    // test sequence
    initial
    begin
        repeat (16) @(posedge clock_in);
        #1 rst_in = 1'b0;
        chk(rm, 16'h0000);
        // ascii single write, echoed through a stalled reply stream
        xfer({8'h01, 8'h06, 8'h00, 8'h42, 8'h00, 8'h02}, 1'b0);
        chk(rm, 16'h0002);
        rep({8'h01, 8'h06, 8'h00, 8'h42, 8'h00, 8'h02});
        chk({g[13], g[14]}, 16'h4235);
        // every error code
        slow = 1'b0;
        xfer({8'h01, 8'h04, 8'h01, 8'h00, 8'h00, 8'h07}, 1'b0);
        rep({8'h01, 8'h84, 8'h01});
        xfer({8'h01, 8'h06, 8'h00, 8'h50, 8'h00, 8'h01}, 1'b0);
        rep({8'h01, 8'h86, 8'h02});
        xfer({8'h01, 8'h10, 8'h00, 8'h40, 8'h00, 8'h01, 8'h03, 8'h00,
            8'h05}, 1'b0);
        rep({8'h01, 8'h90, 8'h03});
        chk(t1, 16'h0000);
        // rtu multiple write of all three registers
        ascii = 1'b0;
        slow = 1'b1;
        xfer({8'h01, 8'h10, 8'h00, 8'h40, 8'h00, 8'h03, 8'h06, 8'h00,
            8'hEB, 8'h01, 8'h5D, 8'h00, 8'h01}, 1'b0);
        chk(t1, 16'h00EB);
        chk(t2, 16'h015D);
        chk(rm, 16'h0001);
        rep({8'h01, 8'h10, 8'h00, 8'h40, 8'h00, 8'h03});
        chk({g[6], g[7]}, 16'h81DC);
        // another address or a spoilt checksum is dropped
        xfer({8'h02, 8'h06, 8'h00, 8'h41, 8'h12, 8'h34}, 1'b0);
        chk(16'(g.size()), 16'h0000);
        xfer({8'h01, 8'h06, 8'h00, 8'h41, 8'h12, 8'h34}, 1'b1);
        chk(16'(g.size()), 16'h0000);
        chk(t2, 16'h015D);
        results();
    end
endmodule : test_mrwh_top
